/* design/cache_maint_map.vh */
`ifndef CACHE_MAINT_MAP_VH
`define CACHE_MAINT_MAP_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_OP 12'h000
`define OFS_ADDR 12'h004
`define OFS_ATTR 12'h008
`define OFS_STATUS 12'h00C
`define OFS_RESULT 12'h010
`define OFS_SEG_DATA 12'h014
`define OFS_SNOOP 12'h018
// ************************************************************
// opcodes written to the op register
// ************************************************************
`define OP_TOUCH 4'h1
`define OP_TOUCH_ST 4'h2
`define OP_ICB_INV 4'h3
`define OP_LINE_SIZE 4'h4
`define OP_ZERO 4'h5
`define OP_STORE 4'h6
`define OP_FLUSH 4'h7
`define OP_SEG_WR 4'h8
`define OP_SEG_RD 4'h9
`define OP_TLB_INV 4'hA
// ************************************************************
// attribute register fields
// ************************************************************
`define ATTR_COHERENT 0
`define ATTR_INHIBIT 1
`define ATTR_WTHRU 2
`define ATTR_IO_SEG 3
`define ATTR_TLB_HIT 4
`define ATTR_BLK_HIT 5
`define ATTR_LOAD_OK 6
`define ATTR_STORE_OK 7
`define ATTR_CACHE_HIT 8
`define ATTR_MODIFIED 9
`define ATTR_SUPER 10
`define ATTR_DTRANS 11
`define ATTR_BUID_LSB 12
`define ATTR_BUID_W 9
// ************************************************************
// constants
// ************************************************************
`define IO_BUID_CACHEABLE 9'h07F
`define LINE_SIZE_BYTES 32'h00000040
`define SEL_ICACHE 5'h0C
`define SEL_DCACHE 5'h0D
`define SEL_MIN 5'h0E
`define SEL_MAX 5'h0F
`define RESET_WORD 32'h00000000
`endif

/* design/seg_reg_file.v */
`include "cache_maint_map.vh"

module seg_reg_file #(
	parameter NUM = 16,
	parameter IW = 4,
	parameter DW = 32
) (
	input wire pclk, // core clock
	input wire presetn, // async reset, active low
	input wire wr_en, // write strobe
	input wire [IW-1:0] idx, // selected segment register
	input wire [DW-1:0] wdata, // write data
	output reg [DW-1:0] rdata // registered read data
);
	reg [DW-1:0] seg_ff [0:NUM-1];
	integer i;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < NUM; i = i + 1) begin
				seg_ff[i] <= `RESET_WORD;
			end
			rdata <= `RESET_WORD;
		end else begin
			if (wr_en) begin
				seg_ff[idx] <= wdata;
			end
			rdata <= seg_ff[idx];
		end
	end
endmodule

/* design/cache_maint_ops.v */
// Operation
// - instruction-cache block invalidate completes as a no-operation.
// - io segment ops proceed only when bus unit id field is 07F.
// - touch fetches only on translation hit with load permission.
// - touch to inhibited or io segment reads bus, cache untouched.
// - touch never updates referenced or changed bits.
// - touch fetches addressed 32-byte sector; second sector optional.
// - successful touch updates TLB and cache LRU state.
// - touch for store behaves exactly as plain touch.
// - line size query returns 64 for selectors 0C to 0F.
// - zero-block hit clears the whole 32-byte block.
// - zero-block miss on cacheable page allocates zeroed block, no read.
// - zero-block on inhibited or write-through page raises alignment fault.
// - zero-block with translation off may allocate unchecked addresses.
// - zero-block checked as store, block-store checked as load.
// - zero-block and block-store in io segment are no-operations.
// - coherent block-store writes back any modified copy anywhere.
// - coherent flush writes back and invalidates everywhere, even on miss.
// - non-coherent flush writes back and invalidates local block only.
// - indirect segment moves index by bits 0-3; supervisor only.
// - tlb invalidate removes local entry and broadcasts on bus.
// - tlb invalidate to io segment neither invalidates nor broadcasts.
// - snooped invalidate blocks new ops, drains, invalidates both ways.
// - after snooped invalidation, normal execution resumes.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "cache_maint_map.vh"

module cache_maint_ops #(
	parameter AW = 32
) (
	input wire pclk, // core clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error on unmapped address
	input wire snoop_tlb_inv, // pin: snooped tlb invalidate
	input wire mem_outstanding, // pin: memory ops still pending
	output reg bus_read_ff, // bus read request pulse
	output reg cache_fill_ff, // fill cache from bus read
	output reg lru_update_ff, // update tlb and cache lru
	output reg zero_block_ff, // clear/allocate block in cache
	output reg write_back_ff, // write back modified block
	output reg inv_local_ff, // invalidate local block
	output reg inv_global_ff, // invalidate copies in all caches
	output reg tlb_inv_local_ff, // invalidate local tlb entry
	output reg tlb_bcast_ff, // broadcast tlb invalidate on bus
	output reg tlb_inv_snoop_ff, // invalidate both indexed ways
	output reg stall_ff, // block new loads, stores, ops, r/c updates
	output reg [AW-1:0] op_addr_ff // address presented with actions
);
	// ************************************************************
	// state
	// ************************************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_DRAIN = 2'b01;
	localparam ST_INVAL = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [3:0] op_ff;
	reg [AW-1:0] addr_ff;
	reg [31:0] attr_ff;
	reg [31:0] result_ff;
	reg [31:0] seg_wdata_ff;
	reg align_fault_ff;
	reg priv_fault_ff;
	reg done_ff;
	reg snoop_count_ff;
	reg [1:0] snoop_sync_ff;
	reg [1:0] out_sync_ff;
	reg issue;
	reg seg_wr;
	wire [31:0] seg_rdata;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snoop_sync_ff <= 2'b00;
			out_sync_ff <= 2'b00;
		end else begin
			snoop_sync_ff <= {snoop_sync_ff[0], snoop_tlb_inv};
			out_sync_ff <= {out_sync_ff[0], mem_outstanding};
		end
	end

	wire snoop_lvl = snoop_sync_ff[1];
	wire busy_mem = out_sync_ff[1];
	reg snoop_prev_ff;
	wire snoop_rise = snoop_lvl & ~snoop_prev_ff;

	// ************************************************************
	// apb slave
	// ************************************************************
	wire acc = psel & penable;
	wire wr_acc = acc & pwrite;
	wire mapped = (paddr == `OFS_OP) | (paddr == `OFS_ADDR) | (paddr == `OFS_ATTR) |
		(paddr == `OFS_STATUS) | (paddr == `OFS_RESULT) | (paddr == `OFS_SEG_DATA) |
		(paddr == `OFS_SNOOP);
	// op writes wait while a snooped invalidate holds the pipeline off
	assign pready = ~(wr_acc & (paddr == `OFS_OP) & (state_ff != ST_IDLE));
	assign pslverr = acc & ~mapped;

	always @* begin
		issue = wr_acc & pready & (paddr == `OFS_OP);
	end

	// ************************************************************
	// attribute decode
	// ************************************************************
	wire a_coh = attr_ff[`ATTR_COHERENT];
	wire a_inh = attr_ff[`ATTR_INHIBIT];
	wire a_wt = attr_ff[`ATTR_WTHRU];
	wire a_io = attr_ff[`ATTR_IO_SEG];
	wire a_hit = attr_ff[`ATTR_TLB_HIT] | attr_ff[`ATTR_BLK_HIT];
	wire a_ld = attr_ff[`ATTR_LOAD_OK];
	wire a_st = attr_ff[`ATTR_STORE_OK];
	wire a_chit = attr_ff[`ATTR_CACHE_HIT];
	wire a_mod = attr_ff[`ATTR_MODIFIED];
	wire a_sup = attr_ff[`ATTR_SUPER];
	wire a_dt = attr_ff[`ATTR_DTRANS];
	wire [8:0] a_buid = attr_ff[`ATTR_BUID_LSB +: `ATTR_BUID_W];
	// io segment with the cacheable bus unit id lets touch and flush proceed
	wire io_pass = ~a_io | (a_buid == `IO_BUID_CACHEABLE);
	wire [3:0] op_w = pwdata[3:0];
	wire [4:0] sel_w = pwdata[8:4];
	wire [3:0] seg_idx = addr_ff[AW-1 -: 4];
	// with translation off, no check is made that the address exists
	wire st_ok = a_dt ? (a_hit & a_st) : 1'b1;
	wire ld_ok = a_dt ? (a_hit & a_ld) : 1'b1;

	always @* begin
		seg_wr = issue & (op_w == `OP_SEG_WR) & a_sup;
	end

	seg_reg_file #(
		.NUM(16),
		.IW(4),
		.DW(32)
	) u_seg (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(seg_wr),
		.idx(seg_idx),
		.wdata(seg_wdata_ff),
		.rdata(seg_rdata)
	);

	// ************************************************************
	// snoop sequencer
	// ************************************************************
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (snoop_rise) begin
					nxt_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (!busy_mem) begin
					nxt_state = ST_INVAL;
				end
			end
			ST_INVAL: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			snoop_prev_ff <= 1'b0;
			snoop_count_ff <= 1'b0;
			stall_ff <= 1'b0;
			tlb_inv_snoop_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			snoop_prev_ff <= snoop_lvl;
			stall_ff <= (nxt_state != ST_IDLE);
			tlb_inv_snoop_ff <= (state_ff == ST_DRAIN) & (nxt_state == ST_INVAL);
			if (state_ff == ST_INVAL) begin
				snoop_count_ff <= ~snoop_count_ff;
			end
		end
	end

	// ************************************************************
	// operation execution
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_ff <= 4'h0;
			addr_ff <= {AW{1'b0}};
			attr_ff <= `RESET_WORD;
			result_ff <= `RESET_WORD;
			seg_wdata_ff <= `RESET_WORD;
			align_fault_ff <= 1'b0;
			priv_fault_ff <= 1'b0;
			done_ff <= 1'b0;
			bus_read_ff <= 1'b0;
			cache_fill_ff <= 1'b0;
			lru_update_ff <= 1'b0;
			zero_block_ff <= 1'b0;
			write_back_ff <= 1'b0;
			inv_local_ff <= 1'b0;
			inv_global_ff <= 1'b0;
			tlb_inv_local_ff <= 1'b0;
			tlb_bcast_ff <= 1'b0;
			op_addr_ff <= {AW{1'b0}};
		end else begin
			bus_read_ff <= 1'b0;
			cache_fill_ff <= 1'b0;
			lru_update_ff <= 1'b0;
			zero_block_ff <= 1'b0;
			write_back_ff <= 1'b0;
			inv_local_ff <= 1'b0;
			inv_global_ff <= 1'b0;
			tlb_inv_local_ff <= 1'b0;
			tlb_bcast_ff <= 1'b0;
			if (wr_acc && paddr == `OFS_ADDR) begin
				addr_ff <= pwdata[AW-1:0];
			end
			if (wr_acc && paddr == `OFS_ATTR) begin
				attr_ff <= pwdata;
			end
			if (wr_acc && paddr == `OFS_SEG_DATA) begin
				seg_wdata_ff <= pwdata;
			end
			// write one to clear; a fault raised in the same cycle wins
			if (wr_acc && paddr == `OFS_STATUS) begin
				align_fault_ff <= align_fault_ff & ~pwdata[1];
				priv_fault_ff <= priv_fault_ff & ~pwdata[2];
			end
			if (issue) begin
				op_ff <= op_w;
				op_addr_ff <= addr_ff;
				done_ff <= 1'b1;
				case (op_w)
					`OP_TOUCH, `OP_TOUCH_ST: begin
						// no r/c update path exists here at all
						if (io_pass && a_hit && a_ld) begin
							bus_read_ff <= ~a_chit;
							cache_fill_ff <= ~a_chit & ~a_inh & ~a_io;
							lru_update_ff <= 1'b1;
						end
					end
					`OP_ICB_INV: begin
						done_ff <= 1'b1;
					end
					`OP_LINE_SIZE: begin
						if (sel_w == `SEL_ICACHE || sel_w == `SEL_DCACHE ||
							sel_w == `SEL_MIN || sel_w == `SEL_MAX) begin
							result_ff <= `LINE_SIZE_BYTES;
						end else begin
							result_ff <= `RESET_WORD;
						end
					end
					`OP_ZERO: begin
						if (!a_io && (a_inh || a_wt)) begin
							align_fault_ff <= 1'b1;
						end else if (!a_io && st_ok) begin
							zero_block_ff <= 1'b1;
							lru_update_ff <= 1'b1;
							inv_global_ff <= a_coh & ~a_chit;
						end
					end
					`OP_STORE: begin
						if (!a_io && ld_ok && a_coh) begin
							write_back_ff <= 1'b1;
						end
					end
					`OP_FLUSH: begin
						if (io_pass) begin
							if (a_coh) begin
								write_back_ff <= a_mod | ~a_chit;
								inv_local_ff <= a_chit;
								inv_global_ff <= 1'b1;
							end else if (a_chit) begin
								write_back_ff <= a_mod;
								inv_local_ff <= 1'b1;
							end
						end
					end
					`OP_SEG_WR, `OP_SEG_RD: begin
						priv_fault_ff <= ~a_sup | priv_fault_ff;
					end
					`OP_TLB_INV: begin
						// software keeps one invalidate in flight at a time
						if (!a_io) begin
							tlb_inv_local_ff <= 1'b1;
							tlb_bcast_ff <= 1'b1;
						end
					end
					default: begin
						done_ff <= 1'b1;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always @* begin
		case (paddr)
			`OFS_OP: prdata = {28'h0000000, op_ff};
			`OFS_ADDR: prdata = addr_ff;
			`OFS_ATTR: prdata = attr_ff;
			`OFS_STATUS: prdata = {27'h0000000, snoop_count_ff, stall_ff,
				priv_fault_ff, align_fault_ff, done_ff};
			`OFS_RESULT: prdata = result_ff;
			`OFS_SEG_DATA: prdata = seg_rdata;
			`OFS_SNOOP: prdata = {30'h00000000, state_ff};
			default: prdata = `RESET_WORD;
		endcase
	end
endmodule

/* test/cache_maint_ops_assertions.sv */
`include "cache_maint_map.vh"
module cache_maint_ops_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic pready, // ready
	input wire logic snoop_tlb_inv, // remote invalidate
	input wire logic bus_read_ff, // bus read
	input wire logic zero_block_ff, // zero block
	input wire logic write_back_ff, // write back
	input wire logic inv_global_ff, // global invalidate
	input wire logic tlb_inv_local_ff, // local tlb kill
	input wire logic tlb_bcast_ff, // tlb broadcast
	input wire logic tlb_inv_snoop_ff, // snoop tlb kill
	input wire logic stall_ff // stall
);
	// ****
	// attribute shadow, taken as the bus takes it
	// ****
	logic [31:0] attr_ff;
	wire logic wr = psel && penable && pready && pwrite;
	wire logic op_wr = wr && paddr == `OFS_OP;
	wire logic [3:0] opc = pwdata[3:0];
	wire logic any_act = bus_read_ff || zero_block_ff || write_back_ff || inv_global_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			attr_ff <= 32'h00000000;
		else if (wr && paddr == `OFS_ATTR)
			attr_ff <= pwdata;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_icbi_quiet: assert property (op_wr && opc == `OP_ICB_INV |=> !any_act)
		else $error("icbi made an action");
	a_touch_gate: assert property (op_wr && (opc == `OP_TOUCH || opc == `OP_TOUCH_ST)
		&& !attr_ff[`ATTR_LOAD_OK] |=> !bus_read_ff) else $error("touch read without load");
	a_zero_fault: assert property (op_wr && opc == `OP_ZERO && attr_ff[`ATTR_DTRANS]
		&& (attr_ff[`ATTR_INHIBIT] || attr_ff[`ATTR_WTHRU]) |=> !zero_block_ff)
		else $error("zero on inhibited page");
	a_tlb_io: assert property (op_wr && opc == `OP_TLB_INV && attr_ff[`ATTR_IO_SEG]
		|=> !tlb_bcast_ff && !tlb_inv_local_ff) else $error("tlb kill in io segment");
	a_tlb_bcast: assert property (op_wr && opc == `OP_TLB_INV && !attr_ff[`ATTR_IO_SEG]
		&& attr_ff[`ATTR_SUPER] |=> tlb_bcast_ff) else $error("tlb kill not broadcast");
	a_flush_all: assert property (op_wr && opc == `OP_FLUSH && attr_ff[`ATTR_COHERENT]
		&& !attr_ff[`ATTR_IO_SEG] && attr_ff[`ATTR_TLB_HIT] && attr_ff[`ATTR_LOAD_OK]
		|=> inv_global_ff) else $error("coherent flush not global");
	a_stall_start: assert property ($rose(snoop_tlb_inv) |-> ##[1:5] stall_ff)
		else $error("snoop did not stall");
	a_snoop_resume: assert property (tlb_inv_snoop_ff |-> ##[1:4] !stall_ff)
		else $error("stall held after snoop");
	c_touch: cover property (bus_read_ff);
	c_flush: cover property (inv_global_ff);
	c_snoop: cover property (tlb_inv_snoop_ff);
endmodule
bind cache_maint_ops cache_maint_ops_checker chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .snoop_tlb_inv(snoop_tlb_inv), .bus_read_ff(bus_read_ff),
	.zero_block_ff(zero_block_ff), .write_back_ff(write_back_ff),
	.inv_global_ff(inv_global_ff), .tlb_inv_local_ff(tlb_inv_local_ff),
	.tlb_bcast_ff(tlb_bcast_ff), .tlb_inv_snoop_ff(tlb_inv_snoop_ff), .stall_ff(stall_ff));

/* test/bus_partner.sv */
module bus_partner (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic go, // start a remote invalidate
	input wire logic [7:0] busy, // cycles memory stays busy
	output logic snoop_tlb_inv, // remote invalidate pin
	output logic mem_outstanding // memory ops pending
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_ff;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 8'h00;
			snoop_tlb_inv <= 1'b0;
			mem_outstanding <= 1'b0;
		end else if (go && cnt_ff == 8'h00) begin
			cnt_ff <= busy + 8'h04;
			snoop_tlb_inv <= 1'b1;
			mem_outstanding <= busy != 8'h00;
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
			snoop_tlb_inv <= cnt_ff > 8'h01;
			mem_outstanding <= cnt_ff > 8'h05;
		end
	end
endmodule

/* test/test_cache_maint_ops.sv */
`include "cache_maint_map.vh"
module test_cache_maint_ops;
	timeunit 1ns;
	timeprecision 1ps;
	// translated, load and store allowed, supervisor, translation on
	localparam logic [31:0] BASE = 32'h00000CD0;
	logic pclk, presetn, psel, penable, pwrite, go;
	logic [11:0] paddr;
	logic [31:0] pwdata, seed, d, a;
	logic [7:0] busy;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, snoop_tlb_inv, mem_outstanding, stall_ff;
	wire logic [8:0] act;
	wire logic snp;
	wire logic [31:0] op_addr;
	logic [65:0] rd_q[$], act_q[$], addr_q[$], snp_q[$];
	int fail_count, n_compared, n;
	cache_maint_ops dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .snoop_tlb_inv(snoop_tlb_inv), .mem_outstanding(mem_outstanding),
		.bus_read_ff(act[8]), .cache_fill_ff(act[7]), .lru_update_ff(act[6]),
		.zero_block_ff(act[5]), .write_back_ff(act[4]), .inv_local_ff(act[3]),
		.inv_global_ff(act[2]), .tlb_inv_local_ff(act[1]), .tlb_bcast_ff(act[0]),
		.tlb_inv_snoop_ff(snp), .stall_ff(stall_ff), .op_addr_ff(op_addr));
	bus_partner far (.pclk(pclk), .presetn(presetn), .go(go), .busy(busy),
		.snoop_tlb_inv(snoop_tlb_inv), .mem_outstanding(mem_outstanding));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task report_and_stop(input bit hung);
		if (hung)
			fail_count++;
		// an expected result that never showed up is a miss too
		fail_count += rd_q.size() + act_q.size() + addr_q.size() + snp_q.size();
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// an empty queue means an action nobody asked for
	task automatic chk(ref logic [65:0] q[$], input logic [32:0] g);
		logic [65:0] e;
		e = q.size() ? q.pop_front() : {{33{1'b1}}, ~g};
		n_compared++;
		if ((g & e[65:33]) !== e[32:0]) begin
			fail_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e[32:0], g);
		end
	endtask
	always @(negedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(rd_q, {pslverr, prdata});
		if (act !== 9'h000)
			chk(act_q, {24'h000000, act});
		if (act !== 9'h000)
			chk(addr_q, {1'b0, op_addr});
		if (snp !== 1'b0)
			chk(snp_q, {31'h00000000, stall_ff, snp});
	end
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		@(posedge pclk);
		if (n == 200)
			report_and_stop(1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [11:0] ad, input logic [32:0] m, input logic [32:0] e);
		rd_q.push_back({m, e});
		apb(1'b0, ad, rnd());
	endtask
	task op(input logic [31:0] w, input logic [31:0] at, input logic [31:0] ad,
		input logic [17:0] e);
		apb(1'b1, `OFS_ATTR, at);
		apb(1'b1, `OFS_ADDR, ad);
		if (e[17:9] != 9'h000)
			act_q.push_back({24'h000000, e[17:9], 24'h000000, e[8:0]});
		if (e[17:9] != 9'h000)
			addr_q.push_back({{33{1'b1}}, 1'b0, ad});
		apb(1'b1, `OFS_OP, w);
	endtask
	initial begin
		seed = 32'hF414887B;
		{psel, penable, pwrite, go, presetn} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		busy = 8'h00;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int c = 1; c < 3; c++) begin
			op(c, BASE, rnd(), {9'h1C0, 9'h1C0});
			op(c, BASE ^ 32'h10, rnd(), 18'h00000);
			op(c, BASE ^ 32'h40, rnd(), 18'h00000);
			op(c, BASE | 32'h2, rnd(), {9'h180, 9'h100});
			op(c, BASE | 32'h7F008, rnd(), {9'h180, 9'h100});
			op(c, BASE | 32'h01008, rnd(), 18'h00000);
		end
		$display("touch tests done");
		op(`OP_ICB_INV, BASE, rnd(), 18'h00000);
		op(`OP_ZERO, BASE | 32'h100, rnd(), {9'h120, 9'h020});
		op(`OP_ZERO, BASE, rnd(), {9'h120, 9'h020});
		op(`OP_ZERO, BASE ^ 32'h80, rnd(), 18'h00000);
		op(`OP_ZERO, BASE | 32'h8, rnd(), 18'h00000);
		op(`OP_ZERO, BASE | 32'h4, rnd(), 18'h00000);
		rd(`OFS_STATUS, 33'h2, 33'h2);
		op(`OP_STORE, BASE | 32'h309, rnd(), 18'h00000);
		op(`OP_STORE, (BASE ^ 32'h40) | 32'h301, rnd(), 18'h00000);
		op(`OP_STORE, BASE | 32'h301, rnd(), {9'h010, 9'h010});
		op(`OP_FLUSH, BASE | 32'h1, rnd(), {9'h00C, 9'h004});
		op(`OP_FLUSH, BASE | 32'h300, rnd(), {9'h01C, 9'h018});
		op(`OP_FLUSH, BASE, rnd(), 18'h00000);
		op(`OP_TLB_INV, BASE, rnd(), {9'h003, 9'h003});
		op(`OP_TLB_INV, BASE | 32'h7F008, rnd(), 18'h00000);
		$display("cache and tlb tests done");
		for (int s = 11; s < 16; s++) begin
			op(`OP_LINE_SIZE | (s << 4), BASE, rnd(), 18'h00000);
			rd(`OFS_RESULT, {33{1'b1}}, s > 11 ? `LINE_SIZE_BYTES : 32'h0);
		end
		for (int i = 0; i < 2; i++) begin
			d = rnd();
			a = (rnd() & 32'h0FFFFFFF) | (i ? 32'hC0000000 : 32'h30000000);
			apb(1'b1, `OFS_SEG_DATA, d);
			op(`OP_SEG_WR, BASE, a, 18'h00000);
			apb(1'b1, `OFS_SEG_DATA, ~d);
			op(`OP_SEG_WR, BASE ^ 32'h400, a, 18'h00000);
			rd(`OFS_SEG_DATA, {33{1'b1}}, {1'b0, d});
		end
		rd(12'h01C, {33{1'b1}}, 33'h100000000);
		$display("query and segment tests done");
		for (int k = 0; k < 2; k++) begin
			busy <= k ? 8'h14 : 8'h00;
			snp_q.push_back({{33{1'b1}}, 33'h000000003});
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			repeat (4) @(posedge pclk);
			op(`OP_TLB_INV, BASE, rnd(), {9'h003, 9'h003});
			n = 0;
			while (snoop_tlb_inv !== 1'b0 && n < 100) begin
				@(posedge pclk);
				n++;
			end
			if (n == 100)
				report_and_stop(1'b1);
		end
		$display("snoop tests done");
		report_and_stop(1'b0);
	end
endmodule
